// *** src/baud_gen.sv ***
// Rate generator with receive majority sampler and Avalon-MM registers
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "baud_gen_defines.svh"
module baud_gen (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire baud_gen_pkg::bus_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Receive side events from the shifter
	input wire baud_gen_pkg::rx_event_t rx_event,
	input wire logic rx_byte_done,
	input wire logic rx_stop_bit,
	// Serial pins
	input wire logic rx_pin,
	// Generator outputs
	output logic bit_tick,
	output logic serial_clock,
	output logic rx_level,
	output logic rx_level_valid,
	output logic irq
);
	import baud_gen_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] transmit_status_control;
	logic [7:0] receive_status_control;
	logic [7:0] baud_divisor;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic ack;
	logic wr_hit;
	logic rd_hit;
	logic divisor_write;
	logic framing_error_flag;
	logic overrun_error_flag;

	assign wr_hit = avs_req.write && !ack;
	assign rd_hit = avs_req.read && !ack;
	assign avs_waitrequest = (avs_req.read || avs_req.write) && !ack;
	assign divisor_write = wr_hit && avs_req.address == 5'(`OFS_DIVISOR);

	// One wait cycle per access
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_req.read || avs_req.write) && !ack;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			transmit_status_control <= `TX_CTRL_RESET;
			receive_status_control <= `RX_CTRL_RESET;
			baud_divisor <= `DIVISOR_RESET;
			irq_enable <= 2'h0;
		end else if (wr_hit) begin
			unique case (avs_req.address)
				5'(`OFS_TX_CTRL): transmit_status_control <= (avs_req.writedata[7:0] & 8'hf5) |
					(transmit_status_control & 8'h02);
				5'(`OFS_RX_CTRL): receive_status_control <= avs_req.writedata[7:0] & 8'hf9;
				5'(`OFS_DIVISOR): baud_divisor <= avs_req.writedata[7:0];
				`OFS_IRQ_ENABLE_W: irq_enable <= avs_req.writedata[1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Receive error flags
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			overrun_error_flag <= 1'b0;
		end else if (rx_event.overrun) begin
			overrun_error_flag <= 1'b1;
		end else if (!receive_status_control[`BIT_CONT_RX]) begin
			overrun_error_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			framing_error_flag <= 1'b0;
		end else if (rx_byte_done) begin
			framing_error_flag <= !rx_stop_bit;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, set wins over clear
	// ------------------------------------------------------------
	logic [1:0] irq_clear;
	assign irq_clear = (wr_hit && avs_req.address == `OFS_IRQ_CLEAR_W) ? avs_req.writedata[1:0] : 2'h0;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_status <= 2'h0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | {rx_event.framing_error || (rx_byte_done && !rx_stop_bit),
				rx_event.overrun};
		end
	end

	assign irq = |(irq_status & irq_enable);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			avs_readdata <= 32'h0;
		end else if (rd_hit) begin
			unique case (avs_req.address)
				5'(`OFS_TX_CTRL): avs_readdata <= {24'h0, transmit_status_control};
				5'(`OFS_RX_CTRL): avs_readdata <= {24'h0, receive_status_control[7:3], framing_error_flag,
					overrun_error_flag, 1'b0};
				5'(`OFS_DIVISOR): avs_readdata <= {24'h0, baud_divisor};
				`OFS_IRQ_STATUS_W: avs_readdata <= {30'h0, irq_status};
				`OFS_IRQ_ENABLE_W: avs_readdata <= {30'h0, irq_enable};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	rate_mode_t mode;
	always_comb begin
		if (!transmit_status_control[`BIT_SYNC]) begin
			mode = transmit_status_control[`BIT_HIGH_SPEED] ? mode_async_high : mode_async_low;
		end else if (transmit_status_control[`BIT_MASTER]) begin
			mode = mode_sync_master;
		end else begin
			mode = mode_sync_slave;
		end
	end

	// ------------------------------------------------------------
	// Rate generator: 8-bit down counter plus prescaler
	// ------------------------------------------------------------
	logic [7:0] rate_count;
	logic [5:0] prescale;
	logic [5:0] prescale_top;
	logic gen_run;
	logic prescale_wrap;
	logic rate_wrap;

	always_comb begin
		unique case (mode)
			mode_async_low: prescale_top = `PRESCALE_ASYNC_LOW;
			mode_async_high: prescale_top = `PRESCALE_ASYNC_HIGH;
			mode_sync_master: prescale_top = `PRESCALE_SYNC;
			mode_sync_slave: prescale_top = `PRESCALE_SYNC;
		endcase
	end

	assign gen_run = receive_status_control[`BIT_PORT_EN] && mode != mode_sync_slave;
	assign prescale_wrap = prescale == 6'h0;
	assign rate_wrap = prescale_wrap && rate_count == 8'h0;

	always_ff @(posedge sys_clk) begin
		if (reset || divisor_write || !gen_run) begin
			prescale <= 6'h0;
			rate_count <= 8'h0;
		end else if (prescale_wrap) begin
			prescale <= prescale_top;
			rate_count <= (rate_count == 8'h0) ? baud_divisor : rate_count - 8'h1;
		end else begin
			prescale <= prescale - 6'h1;
		end
	end

	// Tick counter: 16 ticks per asynchronous bit
	logic [3:0] tick_phase;
	logic tick;
	assign tick = rate_wrap;

	always_ff @(posedge sys_clk) begin
		if (reset || divisor_write || !gen_run) begin
			tick_phase <= 4'h0;
			serial_clock <= 1'b0;
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= tick && (mode == mode_sync_master || tick_phase == 4'hf);
			if (tick) begin
				tick_phase <= tick_phase + 4'h1;
			end
			if (rate_wrap && mode == mode_sync_master) begin
				serial_clock <= !serial_clock;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive pin synchroniser and majority vote
	// ------------------------------------------------------------
	logic rx_meta;
	logic rx_sync;
	logic [2:0] votes;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= rx_pin;
			rx_sync <= rx_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			votes <= 3'h7;
			rx_level <= 1'b1;
			rx_level_valid <= 1'b0;
		end else begin
			rx_level_valid <= 1'b0;
			if (tick && (tick_phase == `SAMPLE_PHASE_A || tick_phase == `SAMPLE_PHASE_B)) begin
				votes <= {votes[1:0], rx_sync};
			end
			if (tick && tick_phase == `SAMPLE_PHASE_C) begin
				rx_level <= (votes[1] & votes[0]) | (votes[1] & rx_sync) | (votes[0] & rx_sync);
				rx_level_valid <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_divisor_clears_timer: assert property (@(posedge sys_clk) disable iff (reset)
		divisor_write |=> rate_count == 8'h0 && prescale == 6'h0) else $error("timer not cleared");
	a_slave_no_clock: assert property (@(posedge sys_clk) disable iff (reset)
		mode == mode_sync_slave |=> !bit_tick) else $error("slave made a tick");
	a_sync_prescale: assert property (@(posedge sys_clk) disable iff (reset)
		gen_run && mode == mode_sync_master && prescale_wrap && !divisor_write |=> prescale == 6'h1)
		else $error("sync prescale wrong");
	a_high_prescale: assert property (@(posedge sys_clk) disable iff (reset)
		gen_run && mode == mode_async_high && prescale_wrap && !divisor_write |=> prescale == `PRESCALE_ASYNC_HIGH)
		else $error("high prescale wrong");
	a_low_prescale: assert property (@(posedge sys_clk) disable iff (reset)
		gen_run && mode == mode_async_low && prescale_wrap && !divisor_write |=> prescale == `PRESCALE_ASYNC_LOW)
		else $error("low prescale wrong");
	a_count_reload: assert property (@(posedge sys_clk) disable iff (reset)
		gen_run && rate_wrap && !divisor_write |=> rate_count == $past(baud_divisor)) else $error("no reload");
	a_overrun_held: assert property (@(posedge sys_clk) disable iff (reset)
		overrun_error_flag && receive_status_control[`BIT_CONT_RX] |=> overrun_error_flag)
		else $error("overrun lost");
	a_framing_set: assert property (@(posedge sys_clk) disable iff (reset)
		rx_byte_done && !rx_stop_bit |=> framing_error_flag) else $error("framing not set");
	a_majority_vote: assert property (@(posedge sys_clk) disable iff (reset)
		tick && tick_phase == `SAMPLE_PHASE_C && votes[1:0] == 2'h3 |=> rx_level) else $error("vote wrong");
endmodule
`default_nettype wire

// *** inc/baud_gen_defines.svh ***
// Offsets, field positions, reset values and timing counts of the rate generator
`ifndef BAUD_GEN_DEFINES_SVH
`define BAUD_GEN_DEFINES_SVH
`define OFS_TX_CTRL 4'h0
`define OFS_RX_CTRL 4'h4
`define OFS_DIVISOR 4'h8
`define OFS_IRQ_STATUS 4'hc
`define OFS_IRQ_CLEAR 4'h0
`define OFS_IRQ_ENABLE 4'h0
`define OFS_IRQ_STATUS_W 5'h0c
`define OFS_IRQ_CLEAR_W 5'h10
`define OFS_IRQ_ENABLE_W 5'h14
`define OFS_RX_EVENT_W 5'h18
`define BIT_MASTER 7
`define BIT_SYNC 4
`define BIT_HIGH_SPEED 2
`define BIT_PORT_EN 7
`define BIT_CONT_RX 4
`define BIT_FRAMING 2
`define BIT_OVERRUN 1
`define TX_CTRL_RESET 8'h02
`define RX_CTRL_RESET 8'h00
`define DIVISOR_RESET 8'h00
`define PRESCALE_ASYNC_LOW 6'h03
`define PRESCALE_ASYNC_HIGH 6'h00
`define PRESCALE_SYNC 6'h01
`define TICK_PER_BIT_LOW 3'h4
`define SAMPLE_PHASE_A 4'h7
`define SAMPLE_PHASE_B 4'h8
`define SAMPLE_PHASE_C 4'h9
`endif

// *** inc/baud_gen_pkg.sv ***
// Types of the rate generator
package baud_gen_pkg;
	typedef enum logic [1:0] {mode_async_low, mode_async_high, mode_sync_master, mode_sync_slave} rate_mode_t;
	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} bus_req_t;
	typedef struct packed {
		logic framing_error;
		logic overrun;
	} rx_event_t;
endpackage

// *** tb/serial_peer.sv ***
// Serial peer driving the receive pin with short glitches
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
	// Clock
	input wire logic sys_clk,
	// Level the bench wants on the line
	input wire logic level,
	// Receive pin
	output var logic rx_pin
);
	int phase = 0;
	initial rx_pin = 1'b1;
	// One clock of inverted level every ninth clock
	always @(posedge sys_clk) begin
		phase <= (phase + 1) % 9;
		rx_pin <= (phase == 0) ? !level : level;
	end
endmodule
`default_nettype wire

// *** tb/test_usart_baud_rate_generator.sv ***
// Testbench of the rate generator
`timescale 1ns/10ps
`default_nettype none
module test_usart_baud_rate_generator;
	import baud_gen_pkg::*;
	logic sys_clk = 0;
	logic reset = 1;
	bus_req_t avs_req = '0;
	rx_event_t rx_event = '0;
	logic rx_byte_done = 0;
	logic rx_stop_bit = 1;
	logic level = 1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, rx_pin, bit_tick, serial_clock, rx_level, rx_level_valid, irq;
	logic [7:0] lfsr = 8'h2f;
	int err_count = 0;
	int checked = 0;
	int m0 = 2;
	int m1 = 0;
	int m2 = 0;
	int st = 0;
	int en = 0;
	int ov = 0;
	int fr = 0;
	always #10 sys_clk = !sys_clk;
	baud_gen u_dut (.sys_clk(sys_clk), .reset(reset), .avs_req(avs_req), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_event(rx_event), .rx_byte_done(rx_byte_done),
		.rx_stop_bit(rx_stop_bit), .rx_pin(rx_pin), .bit_tick(bit_tick), .serial_clock(serial_clock),
		.rx_level(rx_level), .rx_level_valid(rx_level_valid), .irq(irq));
	serial_peer u_peer (.sys_clk(sys_clk), .level(level), .rx_pin(rx_pin));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [7:0] lfsr_step();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	task automatic report_and_stop();
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge sys_clk);
		avs_req <= '{a, !w, w, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_count++;
			report_and_stop();
		end
		q = avs_readdata;
		avs_req <= '0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1, d, q);
		case (a)
			5'h00: m0 = (d & 32'hf5) | 32'h02;
			5'h04: m1 = d & 32'hf8;
			5'h08: m2 = d & 32'hff;
			5'h10: st = st & ~d;
			5'h14: en = d & 3;
			default: ;
		endcase
		if (a == 5'h04 && !d[4])
			ov = 0;
	endtask
	task automatic rd(input logic [4:0] a);
		logic [31:0] q;
		bus(a, 0, 0, q);
		case (a)
			5'h00: check(q, m0);
			5'h04: check(q, m1 | fr << 2 | ov << 1);
			5'h08: check(q, m2);
			5'h0c: check(q, st);
			5'h14: check(q, en);
			default: check(q, 0);
		endcase
		@(negedge sys_clk);
		check(irq, (st & en) != 0);
	endtask
	task automatic pulse(input logic f, input logic o, input logic b, input logic s);
		@(posedge sys_clk);
		rx_event <= '{f, o};
		rx_byte_done <= b;
		rx_stop_bit <= s;
		@(posedge sys_clk);
		rx_event <= '0;
		rx_byte_done <= 0;
		st = st | (f << 1) | o;
		ov = ov | o;
		fr = b ? !s : fr;
	endtask
	task automatic gap(input logic sel, output int n);
		logic last = serial_clock;
		int k;
		n = -1;
		for (k = 0; k < 10000; k++) begin
			@(negedge sys_clk);
			if (n >= 0)
				n++;
			if (sel ? serial_clock !== last : bit_tick === 1'b1) begin
				if (n > 0)
					break;
				n = 0;
			end
			last = serial_clock;
		end
		if (k == 10000) begin
			err_count++;
			report_and_stop();
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int n, x, i, k;
		logic [7:0] modes [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
		int fac [4] = '{64, 16, 2, 2};
		repeat (12) @(posedge sys_clk);
		reset <= 0;
		rd(5'h00);
		rd(5'h04);
		rd(5'h08);
		rd(5'h0c);
		rd(5'h1c);
		wr(5'h00, 32'hff);
		rd(5'h00);
		wr(5'h04, 32'hff);
		rd(5'h04);
		for (i = 0; i < 4; i++) begin
			x = (i == 1) ? 255 : lfsr_step() % 8;
			wr(5'h00, modes[i]);
			wr(5'h08, x);
			rd(5'h08);
			gap(0, n);
			check(n, fac[i] * (x + 1));
			if (i > 1)
				gap(1, n);
			if (i > 1)
				check(n, 2 * (x + 1));
		end
		wr(5'h00, 32'h10);
		n = 0;
		repeat (300) begin
			@(negedge sys_clk);
			n += (bit_tick !== 1'b0);
		end
		check(n, 0);
		wr(5'h00, 32'h04);
		wr(5'h08, 20);
		gap(0, n);
		repeat (100) @(negedge sys_clk);
		wr(5'h08, 2);
		for (n = 0; n < 400 && bit_tick !== 1'b1; n++)
			@(negedge sys_clk);
		check(n >= 40 && n <= 52, 1);
		wr(5'h08, 3);
		for (i = 0; i < 12; i++) begin
			@(posedge sys_clk);
			level <= lfsr_step() > 8'h80;
			for (k = 0; k < 200; k++) begin
				@(negedge sys_clk);
				if (k > 80 && rx_level_valid === 1'b1)
					check(rx_level, level);
			end
		end
		wr(5'h14, 1);
		pulse(0, 1, 0, 1);
		rd(5'h04);
		rd(5'h0c);
		wr(5'h04, 32'h90);
		rd(5'h04);
		wr(5'h04, 32'h80);
		rd(5'h04);
		wr(5'h10, 1);
		pulse(1, 0, 1, 0);
		rd(5'h0c);
		rd(5'h04);
		wr(5'h14, 3);
		rd(5'h14);
		pulse(0, 0, 1, 1);
		rd(5'h04);
		wr(5'h10, 3);
		rd(5'h0c);
		report_and_stop();
	end
endmodule
`default_nettype wire
